//--- src/ssc_sram_ctrl.sv
// control logic of a synchronous burst static ram: command decode, burst
// counter, write masks, flow-through/pipelined read path and output enables
// assumes the array answers arr_rdata combinationally from arr_addr in the
// cycle after the command edge; command pins are synchronous to pclk
//
// Functional notes
// [R1] disabled chip with strobe low deselects, floats data
// [R2] enabled processor strobe low begins read burst
// [R3] controller strobe begins burst, read or write
// [R4] strobes high, advance low: step burst address
// [R5] strobes high, advance high: repeat current address
// [R6] global write all bytes, byte-write by enables
// [R7] any enable mix; none writes nothing
// [R8] reads drive every byte lane
// [R9] writes keep every byte lane floating
// [R10] two lanes only in narrow configuration
// [R11] output enable high kills drivers asynchronously
// [R12] output enable only opens read-activated drivers
// [R13] two-bit counter, linear or interleaved, wraps
// [R14] flow-through when low, pipeline by default
// [R15] sleep high means standby, default active
// [R16] controller may hold strobes for single cycles
// [R17] controller may pulse strobe for simple bursts
// [R18] every listed strobe combination is supported
// [R19] dummy read advances counter like a read
// [R20] low address bits preset the burst counter
// [R21] pipeline read data one clock later
`timescale 1ns/1ps
`default_nettype none

module ssc_sram_ctrl
  import ssc_pkg::*;
#(
  parameter int LANES  = ssc_pkg::LANES_DEF,
  parameter int LANE_W = ssc_pkg::LANE_W_DEF,
  parameter int ADDR_W = ssc_pkg::ADDR_W_DEF
) (
  // clock, reset, enable
  input  wire  logic                             pclk,
  input  wire  logic                             presetn,
  input  wire  logic                             ce,
  // apb slave
  input  wire  logic [ssc_pkg::APB_AW-1:0]       paddr,
  input  wire  logic                             psel,
  input  wire  logic                             penable,
  input  wire  logic                             pwrite,
  input  wire  logic [31:0]                      pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // synchronous bus pins
  input  wire  logic [ADDR_W-1:0]                addr,
  input  wire  logic                             chip_en_a_n,
  input  wire  logic                             chip_en_b,
  input  wire  logic                             chip_en_c_n,
  input  wire  logic                             proc_addr_strobe_n,
  input  wire  logic                             ctrl_addr_strobe_n,
  input  wire  logic                             burst_advance_n,
  input  wire  logic                             global_write_n,
  input  wire  logic                             byte_write_n,
  input  wire  logic                             lane0_write_en_n,
  input  wire  logic                             lane1_write_en_n,
  input  wire  logic                             lane2_write_en_n,
  input  wire  logic                             lane3_write_en_n,
  // asynchronous pins
  input  wire  logic                             out_en_n,
  input  wire  logic                             sleep_req,
  input  wire  logic                             flowthru_sel_n,
  input  wire  logic                             linear_order_n,
  // data pins, split into in, out and active-low enable per lane
  input  wire  logic [LANES*LANE_W-1:0]          dq_in,
  output logic [LANES*LANE_W-1:0]                dq_out,
  output logic [LANES-1:0]                       dq_oe_n,
  // memory array side
  output logic [ADDR_W-1:0]                      arr_addr,
  output logic [LANES*LANE_W-1:0]                arr_wdata,
  output logic [LANES-1:0]                       arr_we,
  output logic                                   arr_re,
  input  wire  logic [LANES*LANE_W-1:0]          arr_rdata,
  output logic                                   standby
);
  import ssc_pkg::*;

  localparam int DW = LANES * LANE_W;

  // burst order: linear adds the count, interleaved xors it
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic               interleave);
    burst_low = interleave ? (start ^ cnt) : BURST_W'(start + cnt); // [R13]
  endfunction

  // mode pin synchronisers
  logic ft_s1_q, ft_s2_q, lin_s1_q, lin_s2_q, slp_s1_q, slp_s2_q;

  // core state
  ssc_acc_t           acc_q, acc_d;
  logic [BURST_W-1:0] start_q, start_d;
  logic [BURST_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0]  arr_addr_q, arr_addr_d;
  logic [DW-1:0]      arr_wdata_q, arr_wdata_d;
  logic [DW-1:0]      pipe_q, pipe_d;
  logic               pipe_vld_q, pipe_vld_d;
  logic [DW-1:0]      dq_out_q, dq_out_d;
  logic               drv_q, drv_d;
  logic               stby_q, stby_d;

  // apb state
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // combinational helpers
  logic                 chip_en;
  logic                 wterm;
  logic [MAX_LANES-1:0] lane_n;
  logic [LANES-1:0]     wmask;
  logic                 ft_mode;
  logic                 stby_now;
  logic [31:0]          stat_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_s1_q  <= FT_SEL_N_RESET;
      ft_s2_q  <= FT_SEL_N_RESET;
      lin_s1_q <= LIN_ORD_N_RESET;
      lin_s2_q <= LIN_ORD_N_RESET;
      slp_s1_q <= SLEEP_RESET;
      slp_s2_q <= SLEEP_RESET;
    end else if (ce) begin
      ft_s1_q  <= flowthru_sel_n;
      ft_s2_q  <= ft_s1_q;
      lin_s1_q <= linear_order_n;
      lin_s2_q <= lin_s1_q;
      slp_s1_q <= sleep_req;
      slp_s2_q <= slp_s1_q;
    end
  end

  always_comb begin
    chip_en  = ~chip_en_a_n & chip_en_b & ~chip_en_c_n;
    lane_n   = {lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n};
    // lanes above the configured count have no pins to obey
    wmask    = ~lane_n[LANES-1:0]; // [R10]
    // global write wins; byte-write alone may write no lane at all
    wterm    = ~global_write_n | ~byte_write_n; // [R6]
    if (!global_write_n) begin
      wmask = '1; // [R6]
    end
    ft_mode  = ~ft_s2_q; // [R14]
    stby_now = slp_s2_q | ctrl_q[CTRL_STANDBY_BIT]; // [R15]
  end

  // command decode and burst counter
  always_comb begin
    acc_d       = '{op: SSC_OP_IDLE, byte_we: '0};
    start_d     = start_q;
    cnt_d       = cnt_q;
    arr_addr_d  = arr_addr_q;
    arr_wdata_d = arr_wdata_q;
    stby_d      = stby_now;
    if (stby_now) begin
      acc_d.op = SSC_OP_IDLE; // [R15]
    end else if (!proc_addr_strobe_n && !chip_en_a_n) begin
      if (chip_en) begin
        // processor strobe ignores the write inputs
        acc_d.op   = SSC_OP_READ; // [R2]
        start_d    = addr[BURST_W-1:0]; // [R20]
        cnt_d      = BURST_FIRST;
        arr_addr_d = addr;
      end else begin
        acc_d.op = SSC_OP_IDLE; // [R1]
      end
    end else if (!ctrl_addr_strobe_n) begin
      if (chip_en) begin
        acc_d.op   = wterm ? SSC_OP_WRITE : SSC_OP_READ; // [R3]
        start_d    = addr[BURST_W-1:0]; // [R20]
        cnt_d      = BURST_FIRST;
        arr_addr_d = addr;
      end else begin
        acc_d.op = SSC_OP_IDLE; // [R1]
      end
    end else begin
      // both remaining strobe forms continue or suspend the burst
      acc_d.op = wterm ? SSC_OP_WRITE : SSC_OP_READ; // [R18]
      if (!burst_advance_n) begin
        // a read with output enable high steps exactly like any read
        cnt_d      = BURST_W'(cnt_q + BURST_STEP); // [R4] [R19]
        arr_addr_d = {arr_addr_q[ADDR_W-1:BURST_W], burst_low(start_q, cnt_d, lin_s2_q)}; // [R13]
      end
      // advance high leaves counter and address as they are [R5]
    end
    if (acc_d.op == SSC_OP_WRITE) begin
      acc_d.byte_we = MAX_LANES'(wmask); // [R7]
      arr_wdata_d   = dq_in;
    end
  end

  // read data path and driver control
  always_comb begin
    pipe_d     = arr_rdata;
    pipe_vld_d = acc_q.op == SSC_OP_READ;
    if (ft_mode) begin
      dq_out_d = arr_rdata;
      drv_d    = acc_q.op == SSC_OP_READ;
    end else begin
      // the extra output register costs one clock of latency
      dq_out_d = pipe_q; // [R21]
      drv_d    = pipe_vld_q; // [R21]
    end
    // a write edge floats the lanes at once; a deselect or standby one edge later,
    // so in flow-through mode a lone read still shows its data for one cycle
    if (acc_d.op == SSC_OP_WRITE || acc_q.op != SSC_OP_READ) begin
      drv_d = 1'b0; // [R1] [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q       <= '{op: SSC_OP_IDLE, byte_we: '0};
      start_q     <= BURST_FIRST;
      cnt_q       <= BURST_FIRST;
      arr_addr_q  <= '0;
      arr_wdata_q <= '0;
      pipe_q      <= '0;
      pipe_vld_q  <= 1'b0;
      dq_out_q    <= '0;
      drv_q       <= 1'b0;
      stby_q      <= 1'b0;
    end else if (ce) begin
      acc_q       <= acc_d;
      start_q     <= start_d;
      cnt_q       <= cnt_d;
      arr_addr_q  <= arr_addr_d;
      arr_wdata_q <= arr_wdata_d;
      pipe_q      <= pipe_d;
      pipe_vld_q  <= pipe_vld_d;
      dq_out_q    <= dq_out_d;
      drv_q       <= drv_d;
      stby_q      <= stby_d;
    end
  end

  // apb slave: answers in the first access cycle
  always_comb begin
    stat_word                                     = '0;
    stat_word[STAT_OP_LSB +: 2]                   = acc_q.op;
    stat_word[STAT_CNT_LSB +: BURST_W]            = cnt_q;
    stat_word[STAT_START_LSB +: BURST_W]          = start_q;
    stat_word[STAT_FT_BIT]                        = ft_s2_q;
    stat_word[STAT_LIN_BIT]                       = lin_s2_q;
    stat_word[STAT_SLEEP_BIT]                     = slp_s2_q;
    stat_word[STAT_DRV_BIT]                       = drv_q;
    stat_word[STAT_STBY_BIT]                      = stby_q;
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = psel & ~penable & ~pready_q;
    if (psel && !penable) begin
      prdata_d = '0;
      if (paddr == REG_CTRL_OFS) begin
        prdata_d = ctrl_q;
      end else if (paddr == REG_STAT_OFS) begin
        prdata_d = stat_word;
      end else begin
        pslverr_d = 1'b1;
      end
    end else if (psel && penable && !pready_q) begin
      pslverr_d = pslverr_q;
    end
    if (psel && penable && pready_q && pwrite && paddr == REG_CTRL_OFS) begin
      // only the standby bit is implemented, the rest read zero
      ctrl_d                   = '0;
      ctrl_d[CTRL_STANDBY_BIT] = pwdata[CTRL_STANDBY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // output enable is gated without a clock so it can cut drivers at any moment;
  // it can never open a lane the clocked logic has not armed for a read
  assign dq_oe_n   = {LANES{~(drv_q & ~out_en_n)}}; // [R8] [R11] [R12]
  assign dq_out    = dq_out_q;
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign arr_addr  = arr_addr_q;
  assign arr_wdata = arr_wdata_q;
  assign arr_we    = acc_q.byte_we[LANES-1:0];
  assign arr_re    = acc_q.op == SSC_OP_READ;
  assign standby   = stby_q;

endmodule

`default_nettype wire

//--- src/ssc_pkg.sv
// constants, enumerations and carriers for the sync burst sram control block
// assumes one 100 MHz clock; every consumer imports the whole package
package ssc_pkg;

  // configuration defaults: lane count, lane width, array address width
  localparam int MAX_LANES  = 4;
  localparam int LANES_DEF  = 4;
  localparam int LANE_W_DEF = 9;
  localparam int ADDR_W_DEF = 19;
  localparam int APB_AW     = 12;

  // apb register map, byte addresses
  localparam logic [11:0] REG_CTRL_OFS = 12'h000;
  localparam logic [11:0] REG_STAT_OFS = 12'h004;

  // control register layout and reset value
  localparam int          CTRL_STANDBY_BIT = 0;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // status register layout
  localparam int STAT_OP_LSB    = 0;
  localparam int STAT_CNT_LSB   = 2;
  localparam int STAT_START_LSB = 4;
  localparam int STAT_FT_BIT    = 6;
  localparam int STAT_LIN_BIT   = 7;
  localparam int STAT_SLEEP_BIT = 8;
  localparam int STAT_DRV_BIT   = 9;
  localparam int STAT_STBY_BIT  = 10;

  // values after reset of the mode synchronisers (pull-up and pull-down defaults)
  localparam logic FT_SEL_N_RESET  = 1'b1;
  localparam logic LIN_ORD_N_RESET = 1'b0;
  localparam logic SLEEP_RESET     = 1'b0;

  // burst counter
  localparam int         BURST_W     = 2;
  localparam logic [1:0] BURST_FIRST = 2'h0;
  localparam logic [1:0] BURST_STEP  = 2'h1;

  // kind of array access decoded on a clock edge
  typedef enum logic [1:0] {
    SSC_OP_IDLE  = 2'b00,
    SSC_OP_READ  = 2'b01,
    SSC_OP_WRITE = 2'b10
  } ssc_op_t;

  // one decoded access: kind and per-lane write mask
  typedef struct packed {
    ssc_op_t              op;
    logic [MAX_LANES-1:0] byte_we;
  } ssc_acc_t;

endpackage

//--- verif/ssc_sram_ctrl_checker.sv
// concurrent checks on the pins of the burst sram control block
// assumes ce held high; bound onto every ssc_sram_ctrl
`timescale 1ns/1ps
`default_nettype none
module ssc_sram_ctrl_checker #(
  parameter int LANES  = 4,
  parameter int ADDR_W = 19
) (
  // clock, reset, apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  // command pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              chip_en_a_n,
  input wire logic              chip_en_b,
  input wire logic              chip_en_c_n,
  input wire logic              proc_addr_strobe_n,
  input wire logic              ctrl_addr_strobe_n,
  input wire logic              burst_advance_n,
  input wire logic              global_write_n,
  input wire logic              byte_write_n,
  input wire logic              lane0_write_en_n,
  input wire logic              lane1_write_en_n,
  input wire logic              lane2_write_en_n,
  input wire logic              lane3_write_en_n,
  input wire logic              out_en_n,
  // outputs
  input wire logic [LANES-1:0]  dq_oe_n,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [LANES-1:0]  arr_we,
  input wire logic              arr_re,
  input wire logic              standby
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic              en;
  logic              dsel;
  logic              cont;
  logic              beg_c;
  logic [3:0]        lane_all;
  logic [LANES-1:0]  lane_we;
  logic [ADDR_W-3:0] arr_hi;
  logic [1:0]        arr_lo;
  assign en = !chip_en_a_n && chip_en_b && !chip_en_c_n;
  assign dsel = !en && (!ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_en_a_n));
  assign cont = ctrl_addr_strobe_n && (proc_addr_strobe_n || chip_en_a_n);
  assign beg_c = en && proc_addr_strobe_n && !ctrl_addr_strobe_n;
  assign lane_all = ~{lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n};
  assign lane_we = lane_all[LANES-1:0];
  assign arr_hi = arr_addr[ADDR_W-1:2];
  assign arr_lo = arr_addr[1:0];
  // standby seen one edge after a command means the command was swallowed
  a_oe_async_off: assert property (out_en_n |-> &dq_oe_n) else $error("drivers on with output enable high");
  a_lanes_equal: assert property (dq_oe_n == {LANES{dq_oe_n[0]}}) else $error("lane enables differ");
  a_write_floats: assert property (|arr_we |-> &dq_oe_n) else $error("driving during write");
  a_deselect_idle: assert property (dsel |=> !arr_re && arr_we == '0 ##1 &dq_oe_n)
    else $error("deselect still accesses or drives");
  a_proc_read: assert property (en && !proc_addr_strobe_n
    |=> standby || (arr_re && arr_we == '0 && arr_addr == $past(addr))) else $error("processor strobe read wrong");
  a_global_write: assert property (beg_c && !global_write_n |=> standby || (!arr_re && &arr_we))
    else $error("global write");
  a_byte_mask: assert property (beg_c && global_write_n && !byte_write_n
    |=> standby || (!arr_re && arr_we == $past(lane_we))) else $error("byte write mask wrong");
  a_ctrl_read: assert property (beg_c && global_write_n && byte_write_n
    |=> standby || (arr_re && arr_we == '0)) else $error("controller strobe read wrong");
  a_suspend_hold: assert property (cont && burst_advance_n |=> $stable(arr_addr))
    else $error("suspend moved the address");
  a_continue_step: assert property (cont && !burst_advance_n
    |=> standby || (arr_hi == $past(arr_hi) && arr_lo != $past(arr_lo))) else $error("continue did not step");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
endmodule
bind ssc_sram_ctrl ssc_sram_ctrl_checker #(.LANES(LANES), .ADDR_W(ADDR_W)) ssc_sram_ctrl_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .addr(addr), .chip_en_a_n(chip_en_a_n), .chip_en_b(chip_en_b), .chip_en_c_n(chip_en_c_n),
  .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .burst_advance_n(burst_advance_n), .global_write_n(global_write_n), .byte_write_n(byte_write_n),
  .lane0_write_en_n(lane0_write_en_n), .lane1_write_en_n(lane1_write_en_n),
  .lane2_write_en_n(lane2_write_en_n), .lane3_write_en_n(lane3_write_en_n), .out_en_n(out_en_n),
  .dq_oe_n(dq_oe_n), .arr_addr(arr_addr), .arr_we(arr_we), .arr_re(arr_re), .standby(standby)
);
`default_nettype wire

//--- verif/ssc_array_model.sv
// behavioural storage array behind the control block, 16 words deep
// assumes 4 lanes of 9 bits; writes land one edge after arr_we rises
`timescale 1ns/1ps
`default_nettype none
module ssc_array_model (
  // array side of the control block
  input wire logic        pclk,
  input wire logic [18:0] arr_addr,
  input wire logic [35:0] arr_wdata,
  input wire logic [3:0]  arr_we,
  input wire logic        arr_re,
  output logic [35:0]     arr_rdata
);
  logic [35:0] mem [16];
  logic [35:0] junk = 36'h5_A5A5_A5A5;
  always @(posedge pclk) begin
    junk <= ~junk;
    for (int l = 0; l < 4; l++) begin
      if (arr_we[l]) mem[arr_addr[3:0]][l*9 +: 9] <= arr_wdata[l*9 +: 9];
    end
  end
  // toggling junk when not read, so stale data never looks valid
  assign arr_rdata = arr_re ? mem[arr_addr[3:0]] : junk;
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for ssc_sram_ctrl with array model and apb master
// assumes default parameters: 4 lanes of 9 bits, 19 address bits
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssc_pkg::*;
  // {proc, ctrl, advance, en_a, en_b, en_c} strobe patterns
  localparam logic [5:0] IDLE = 6'h2E, BEG_C = 6'h2A, BEG_P = 6'h1A, CONT = 6'h32, CONT2 = 6'h16;
  localparam logic [5:0] SUSP = 6'h3A, DSB = 6'h18, DSC = 6'h2B, RD = 6'h3F, WALL = 6'h1F;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rng = 32'h11;
  logic pready, pslverr, err, arr_re, standby, out_en_n = 1'b0, sleep_req = 1'b0;
  logic flowthru_sel_n = 1'b1, linear_order_n = 1'b0, global_write_n = 1'b1, byte_write_n = 1'b1;
  logic proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b0, burst_advance_n = 1'b1;
  logic chip_en_a_n = 1'b1, chip_en_b = 1'b1, chip_en_c_n = 1'b0;
  logic lane0_write_en_n = 1'b1, lane1_write_en_n = 1'b1, lane2_write_en_n = 1'b1, lane3_write_en_n = 1'b1;
  logic [3:0] dq_oe_n, arr_we, ln;
  logic [18:0] addr = 19'h0, arr_addr, st;
  logic [35:0] dq_in = 36'h0, dq_out, arr_wdata, arr_rdata, wd, ex;
  int errors = 0;
  int cmp_count = 0;
  ssc_sram_ctrl ssc_sram_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr(addr), .chip_en_a_n(chip_en_a_n), .chip_en_b(chip_en_b), .chip_en_c_n(chip_en_c_n),
    .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .global_write_n(global_write_n), .byte_write_n(byte_write_n),
    .lane0_write_en_n(lane0_write_en_n), .lane1_write_en_n(lane1_write_en_n),
    .lane2_write_en_n(lane2_write_en_n), .lane3_write_en_n(lane3_write_en_n),
    .out_en_n(out_en_n), .sleep_req(sleep_req), .flowthru_sel_n(flowthru_sel_n),
    .linear_order_n(linear_order_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_we(arr_we), .arr_re(arr_re), .arr_rdata(arr_rdata),
    .standby(standby)
  );
  ssc_array_model ssc_array_model_inst (
    .pclk(pclk), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_we(arr_we), .arr_re(arr_re),
    .arr_rdata(arr_rdata)
  );
  always #5 pclk = ~pclk;
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [1:0] burst_low(logic [1:0] s, logic [1:0] c, logic il);
    return il ? (s ^ c) : (s + c);
  endfunction
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] ln);
    for (int l = 0; l < 4; l++) begin
      if (!ln[l]) o[l*9 +: 9] = n[l*9 +: 9];
    end
    return o;
  endfunction
  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one command edge; outputs seen on return belong to the previous command
  task automatic cmd(input logic [5:0] s, input logic [5:0] w, input logic [18:0] a);
    rd = xs();
    wd = {rd[3:0], xs()};
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_en_a_n, chip_en_b, chip_en_c_n} <= s;
    {global_write_n, byte_write_n, lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n} <= w;
    addr <= a;
    dq_in <= wd;
    @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      linear_order_n <= m[0];
      out_en_n <= m[1];
      repeat (3) cmd(m[0] ? DSB : DSC, RD, 19'h0);
      rd = xs();
      st = rd[18:0];
      cmd(m[1] ? BEG_P : BEG_C, m[1] ? WALL : RD, st);
      for (int i = 0; i < 5; i++) begin
        rd = xs();
        cmd(i == 4 ? IDLE : (m[0] ? CONT2 : CONT), RD, rd[18:0]);
        chk("burst_low", 36'(burst_low(st[1:0], i[1:0], m[0])), 36'(arr_addr[1:0]));
      end
    end
    out_en_n <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      flowthru_sel_n <= f[0];
      repeat (3) cmd(IDLE, RD, 19'h0);
      rd = xs();
      st = rd[18:0];
      cmd(BEG_C, WALL, st);
      ex = wd;
      rd = xs();
      ln = rd[3:0];
      cmd(BEG_C, {2'b10, ln}, st);
      ex = merge(ex, wd, ln);
      cmd(BEG_P, RD, st);
      cmd(SUSP, RD, st);
      cmd(SUSP, RD, st);
      chk("oe_first", 36'(f[0] ? 4'hF : 4'h0), 36'(dq_oe_n));
      cmd(IDLE, RD, st);
      chk("rdata", ex, dq_out);
      chk("oe_second", 36'h0, 36'(dq_oe_n));
      cmd(IDLE, RD, st);
      chk("oe_last", 36'h0, 36'(dq_oe_n));
      cmd(IDLE, RD, st);
      chk("oe_off", 36'hF, 36'(dq_oe_n));
    end
    sleep_req <= 1'b1;
    repeat (3) cmd(IDLE, RD, 19'h0);
    cmd(BEG_P, RD, st);
    cmd(IDLE, RD, st);
    chk("sleep_access", 36'h2, 36'({standby, arr_re}));
    sleep_req <= 1'b0;
    repeat (3) cmd(IDLE, RD, 19'h0);
    apb(1'b1, REG_CTRL_OFS, 32'h1);
    apb(1'b0, REG_STAT_OFS, 32'h0);
    chk("stat_standby", 36'h1, 36'(rd[STAT_STBY_BIT]));
    apb(1'b1, REG_CTRL_OFS, 32'h0);
    apb(1'b0, REG_CTRL_OFS, 32'h0);
    chk("ctrl_clear", 36'h0, 36'(rd));
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 36'h1_0000_0000, {3'h0, err, rd});
    complete_run();
  end
endmodule
`default_nettype wire
